// ---- pkg/trig_seq_pkg.sv ----
// Purpose: Shared constants and types of the measurement trigger sequencer
// Assumes: 40 MHz clock, one clock domain
// Notes:   Contract
// Contract
// - Triggers are taken only from the selected source.
// - Auto mode takes readings back to back as fast as possible.
// - Entering auto forces unlimited sample count and starts measuring.
// - Single mode: each press or external edge starts one burst.
// - Waiting-for-trigger output is high while armed.
// - Hold updates only on stable readings; beeps on capture if enabled.
// - Hold cancels on function change, remote entry or manual range.
// - Immediate source triggers at once; default for remote operation.
// - Configure and measure commands set source to immediate.
// - Bus source starts readings only on a bus trigger after arming.
// - Internal source triggers on level crossing, V, I and R only.
// - Default one sample per trigger; up to 50,000 or 1 million. Reset loads a count of zero (unlimited) instead.
// - Programmed number of pre-trigger samples is kept.
// - No pre-trigger retention for continuity and diode test.
// - Trigger delay ranges from 0 to 3600 seconds.
// - Continuity and diode test apply no delay.
// - In automatic delay mode an automatic delay input is used.
// - Manual delay applies to all functions but continuity and diode.
// - Delay choices: automatic, zero or manual.
// - Measure command resets delay to automatic.
// - One external trigger during a reading is latched and issued after.
`default_nettype none
package trig_seq_pkg;
  localparam int unsigned CLOCK_HZ        = 40_000_000;
  localparam int unsigned DELAY_MAX_S     = 3600;
  localparam int unsigned TICK_US         = 1;
  localparam int unsigned TICK_CYCLES     = CLOCK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned COUNT_MAX_STD   = 50_000;
  localparam int unsigned COUNT_MAX_EXT   = 1_000_000;
  localparam int unsigned COUNT_W         = 20;
  localparam int unsigned DELAY_W         = 32;
  localparam logic [19:0] COUNT_RESET     = 20'h00001;
  localparam logic [19:0] PRETRIG_RESET   = 20'h00000;
  localparam logic [31:0] DELAY_RESET     = 32'h00000000;
  localparam logic [31:0] DELAY_MAX_US    = 32'hd693a400;

  typedef enum logic [2:0] {
    SRC_AUTO, SRC_SINGLE, SRC_HOLD, SRC_IMMEDIATE, SRC_BUS, SRC_EXTERNAL,
    SRC_INTERNAL
  } source_t;
  typedef enum logic [1:0] {DLY_AUTO, DLY_ZERO, DLY_MANUAL} delay_mode_t;
  typedef enum logic [2:0] {
    FN_DCV, FN_ACV, FN_DCI, FN_ACI, FN_RES2, FN_RES4, FN_CONT, FN_DIODE
  } function_t;
endpackage
`default_nettype wire

// ---- hw/edge_sync.sv ----
// Purpose: Two-flop synchroniser with rising or falling edge pulse
// Assumes: Input asynchronous to clock
// Notes:   First flop read only by the second
`default_nettype none
module edge_sync (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Pin side
  input  wire logic pin,
  input  wire logic rising,
  // Logic side
  output logic      edge_pulse
);
  logic meta, sync, prev;
  logic next_pulse;

  always_comb begin
    next_pulse = rising ? (sync & ~prev) : (~sync & prev);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta       <= 1'b0;
      sync       <= 1'b0;
      prev       <= 1'b0;
      edge_pulse <= 1'b0;
    end else begin
      meta       <= pin;
      sync       <= meta;
      prev       <= sync;
      edge_pulse <= next_pulse;
    end
  end
endmodule // edge_sync
`default_nettype wire

// ---- hw/delay_timer.sv ----
// Purpose: Microsecond delay timer for the trigger delay
// Assumes: Start pulse loads a delay in microseconds
// Notes:   Zero delay raises done two cycles after the start pulse
`default_nettype none
module delay_timer
  import trig_seq_pkg::*;
#(
  parameter int unsigned TICK = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst_n,
  // Control
  input  wire logic               start,
  input  wire logic [DELAY_W-1:0] delay_us,
  // Status
  output logic                    done
);
  logic [DELAY_W-1:0] remain, next_remain;
  logic [7:0]         tick, next_tick;
  logic               busy, next_busy, next_done;

  always_comb begin
    next_remain = remain;
    next_tick   = tick;
    next_busy   = busy;
    next_done   = 1'b0;
    if (start) begin
      next_remain = delay_us;
      next_tick   = 8'h00;
      next_busy   = 1'b1;
    end else if (busy) begin
      if (remain == '0) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else if (tick == 8'(TICK - 1)) begin
        next_tick   = 8'h00;
        next_remain = remain - 1'b1;
      end else begin
        next_tick = tick + 8'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      remain <= '0;
      tick   <= 8'h00;
      busy   <= 1'b0;
      done   <= 1'b0;
    end else begin
      remain <= next_remain;
      tick   <= next_tick;
      busy   <= next_busy;
      done   <= next_done;
    end
  end
endmodule // delay_timer
`default_nettype wire

// ---- hw/trigger_sequencer.sv ----
// Purpose: Trigger sequencer: source select, delay, sample bursts, hold
// Assumes: Engine pulses sample_done once per requested sample
// Notes:   Count of zero means unlimited samples
`default_nettype none
module trigger_sequencer
  import trig_seq_pkg::*;
#(
  parameter bit EXTENDED = 1'b0
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // Configuration
  input  wire trig_seq_pkg::source_t     source_sel,
  input  wire logic                 source_load,
  input  wire logic [COUNT_W-1:0]   sample_count,
  input  wire logic [COUNT_W-1:0]   pretrigger_count,
  input  wire logic                 count_load,
  input  wire trig_seq_pkg::delay_mode_t delay_mode,
  input  wire logic [DELAY_W-1:0]   manual_delay_us,
  input  wire logic                 delay_load,
  input  wire trig_seq_pkg::function_t   meas_function,
  input  wire logic [DELAY_W-1:0]   auto_delay_us,
  input  wire logic                 beeper_enable,
  // Commands
  input  wire logic                 cmd_configure,
  input  wire logic                 cmd_measure,
  input  wire logic                 cmd_arm,
  input  wire logic                 cmd_abort,
  input  wire logic                 cmd_bus_trigger,
  input  wire logic                 key_trigger,
  input  wire logic                 remote_enter,
  input  wire logic                 range_manual,
  // Engine and external trigger
  input  wire logic                 ext_trig_pin,
  input  wire logic                 ext_slope_pos,
  input  wire logic                 level_rising,
  input  wire logic                 level_falling,
  input  wire logic                 level_slope_pos,
  input  wire logic                 reading_stable,
  input  wire logic                 sample_done,
  // Status and engine control
  output logic                      sample_req,
  output logic                      pretrig_active,
  output logic                      waiting_trigger,
  output logic                      hold_capture,
  output logic                      beep,
  output trig_seq_pkg::source_t          source,
  output logic [COUNT_W-1:0]        count_cfg,
  output logic [COUNT_W-1:0]        pretrig_cfg,
  output trig_seq_pkg::delay_mode_t      delay_cfg,
  output logic                      burst_done
);
  import trig_seq_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_DELAY, ST_SAMPLE, ST_HOLD
  } state_t;

  localparam logic [COUNT_W-1:0] COUNT_LIMIT =
    EXTENDED ? COUNT_W'(COUNT_MAX_EXT) : COUNT_W'(COUNT_MAX_STD);

  ////////////////////////////////////////////////////////////////////////////
  // External trigger synchroniser and delay timer
  logic ext_edge;
  logic timer_start, timer_done;
  logic [DELAY_W-1:0] timer_load;

  edge_sync ext_sync (
    .clock      (clock),
    .rst_n      (rst_n),
    .pin        (ext_trig_pin),
    .rising     (ext_slope_pos),
    .edge_pulse (ext_edge)
  );

  delay_timer dly (
    .clock    (clock),
    .rst_n    (rst_n),
    .start    (timer_start),
    .delay_us (timer_load),
    .done     (timer_done)
  );

  function automatic logic no_delay_fn(input function_t f);
    return (f == FN_CONT) || (f == FN_DIODE);
  endfunction

  function automatic logic [COUNT_W-1:0] clamp_count(
      input logic [COUNT_W-1:0] c);
    return (c > COUNT_LIMIT) ? COUNT_LIMIT : c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  state_t             state, next_state;
  source_t            next_source;
  delay_mode_t        next_delay_cfg;
  logic [DELAY_W-1:0] manual_dly, next_manual_dly;
  logic [COUNT_W-1:0] next_count_cfg, next_pretrig_cfg;
  logic [COUNT_W-1:0] taken, next_taken;
  logic               ext_pending, next_ext_pending;
  function_t          last_fn;
  logic               next_sample_req, next_pretrig_active, next_waiting;
  logic               next_hold_capture, next_beep, next_burst_done;
  logic               trig_event, level_hit, fn_change;

  always_comb begin
    fn_change = (meas_function != last_fn);
    level_hit = (meas_function != FN_CONT) && (meas_function != FN_DIODE)
              && (level_slope_pos ? level_rising : level_falling);
    trig_event = 1'b0;
    case (source)
      SRC_IMMEDIATE: trig_event = 1'b1;
      SRC_BUS:       trig_event = cmd_bus_trigger;
      SRC_EXTERNAL:  trig_event = ext_edge | ext_pending;
      SRC_SINGLE:    trig_event = key_trigger | ext_edge | ext_pending;
      SRC_INTERNAL:  trig_event = level_hit;
      default:       trig_event = 1'b0;
    endcase
  end

  always_comb begin
    next_state          = state;
    next_source         = source;
    next_delay_cfg      = delay_cfg;
    next_manual_dly     = manual_dly;
    next_count_cfg      = count_cfg;
    next_pretrig_cfg    = pretrig_cfg;
    next_taken          = taken;
    next_ext_pending    = ext_pending;
    next_sample_req     = 1'b0;
    next_hold_capture   = 1'b0;
    next_beep           = 1'b0;
    next_burst_done     = 1'b0;
    timer_start         = 1'b0;
    timer_load          = '0;

    if (count_load) begin
      next_count_cfg   = clamp_count(sample_count);
      next_pretrig_cfg = pretrigger_count;
    end
    if (delay_load) begin
      next_delay_cfg  = delay_mode;
      next_manual_dly = (manual_delay_us > DELAY_MAX_US) ?
                        DELAY_MAX_US : manual_delay_us;
    end
    if (cmd_configure || cmd_measure) next_source = SRC_IMMEDIATE;
    if (cmd_measure) next_delay_cfg = DLY_AUTO;
    if (source_load) begin
      next_source = source_sel;
      if (source_sel == SRC_AUTO) next_count_cfg = '0;
    end

    // External edge during a reading is kept for later
    if (ext_edge && (state == ST_SAMPLE || state == ST_DELAY))
      next_ext_pending = 1'b1;

    case (state)
      ST_IDLE: begin
        if (cmd_arm) next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (trig_event) begin
          next_ext_pending = 1'b0;
          next_taken       = '0;
          next_state       = ST_DELAY;
          timer_start      = 1'b1;
          if (no_delay_fn(meas_function) || delay_cfg == DLY_ZERO)
            timer_load = '0;
          else if (delay_cfg == DLY_MANUAL)
            timer_load = manual_dly;
          else
            timer_load = auto_delay_us;
        end
      end
      ST_DELAY: begin
        if (timer_done) begin
          next_state      = ST_SAMPLE;
          next_sample_req = 1'b1;
        end
      end
      ST_SAMPLE: begin
        if (sample_done) begin
          next_taken = taken + 1'b1;
          if (source == SRC_AUTO) begin
            next_sample_req = 1'b1;
          end else if (count_cfg != '0 && taken + 1'b1 >= count_cfg) begin
            next_burst_done = 1'b1;
            next_state      = ST_WAIT;
          end else begin
            next_sample_req = 1'b1;
          end
        end
      end
      ST_HOLD: begin
        if (reading_stable) begin
          next_hold_capture = 1'b1;
          next_beep         = beeper_enable;
        end
        if (fn_change || remote_enter || range_manual)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase

    // Source change restarts the sequence in its own mode
    if (source_load) begin
      case (source_sel)
        SRC_AUTO: begin
          next_state = ST_DELAY;
          timer_start = 1'b1;
          timer_load  = '0;
        end
        SRC_HOLD: next_state = ST_HOLD;
        SRC_SINGLE: next_state = ST_WAIT;
        default: next_state = ST_IDLE;
      endcase
    end
    if (cmd_abort) next_state = ST_IDLE;
    if (state == ST_HOLD && (fn_change || remote_enter || range_manual))
      next_source = SRC_IMMEDIATE;
  end

  always_comb begin
    next_waiting = (next_state == ST_WAIT);
    next_pretrig_active = (next_state == ST_WAIT) && (pretrig_cfg != '0)
                        && !no_delay_fn(meas_function);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state           <= ST_DELAY;
      source          <= SRC_AUTO;
      delay_cfg       <= DLY_AUTO;
      manual_dly      <= DELAY_RESET;
      count_cfg       <= '0;
      pretrig_cfg     <= PRETRIG_RESET;
      taken           <= '0;
      ext_pending     <= 1'b0;
      last_fn         <= FN_DCV;
      sample_req      <= 1'b0;
      pretrig_active  <= 1'b0;
      waiting_trigger <= 1'b0;
      hold_capture    <= 1'b0;
      beep            <= 1'b0;
      burst_done      <= 1'b0;
    end else begin
      state           <= next_state;
      source          <= next_source;
      delay_cfg       <= next_delay_cfg;
      manual_dly      <= next_manual_dly;
      count_cfg       <= next_count_cfg;
      pretrig_cfg     <= next_pretrig_cfg;
      taken           <= next_taken;
      ext_pending     <= next_ext_pending;
      last_fn         <= meas_function;
      sample_req      <= next_sample_req;
      pretrig_active  <= next_pretrig_active;
      waiting_trigger <= next_waiting;
      hold_capture    <= next_hold_capture;
      beep            <= next_beep;
      burst_done      <= next_burst_done;
    end
  end
endmodule // trigger_sequencer
`default_nettype wire

// ---- verification/engine_model.sv ----
// Purpose: Measurement engine model answering sample requests
// Assumes: One sample_req pulse per sample
// Notes:   slow stretches each reading to 20 cycles
`default_nettype none
module engine_model (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Sequencer side
  input  wire logic sample_req,
  input  wire logic slow,
  output var  logic sample_done
);
  timeunit 1ns;
  timeprecision 100ps;
  int  cnt;
  logic busy;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      cnt <= 0;
      sample_done <= 1'b0;
    end else begin
      sample_done <= 1'b0;
      if (sample_req) begin
        busy <= 1'b1;
        cnt <= slow ? 20 : 1;
      end else if (busy) begin
        if (cnt == 1) begin
          busy <= 1'b0;
          sample_done <= 1'b1;
        end
        cnt <= cnt - 1;
      end
    end
  end
endmodule // engine_model
`default_nettype wire

// ---- verification/trig_seq_chk.sv ----
// Purpose: Port checker for the trigger sequencer
// Assumes: Timed burst property only with zero delay
// Notes:   Bound at the foot of this file
`default_nettype none
module trig_seq_chk
  import trig_seq_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Inputs watched
  input wire trig_seq_pkg::source_t source_sel,
  input wire logic source_load,
  input wire logic [COUNT_W-1:0] sample_count,
  input wire logic count_load,
  input wire logic delay_load,
  input wire logic cmd_configure,
  input wire logic cmd_measure,
  input wire logic cmd_abort,
  input wire logic cmd_bus_trigger,
  input wire logic remote_enter,
  input wire logic range_manual,
  // Outputs watched
  input wire logic sample_req,
  input wire logic pretrig_active,
  input wire logic waiting_trigger,
  input wire logic hold_capture,
  input wire logic beep,
  input wire trig_seq_pkg::source_t source,
  input wire logic [COUNT_W-1:0] count_cfg,
  input wire trig_seq_pkg::delay_mode_t delay_cfg,
  input wire logic burst_done
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic quiet;
  assign quiet = !(cmd_abort || source_load || cmd_configure || cmd_measure
                   || remote_enter || range_manual);
  property p_cfg;
    cmd_configure && !source_load |=> source == SRC_IMMEDIATE;
  endproperty
  a_cfg: assert property (p_cfg) else $error("source not immediate");
  property p_meas;
    cmd_measure && !delay_load |=> delay_cfg == DLY_AUTO;
  endproperty
  a_meas: assert property (p_meas) else $error("delay not auto");
  property p_auto;
    source_load && source_sel == SRC_AUTO && !cmd_configure && !cmd_measure
      && !count_load |=> source == SRC_AUTO && count_cfg == 20'h00000;
  endproperty
  a_auto: assert property (p_auto) else $error("auto entry wrong");
  property p_clamp;
    count_load && !source_load && source != SRC_AUTO
      && sample_count > 20'h0c350 |=> count_cfg == 20'h0c350;
  endproperty
  a_clamp: assert property (p_clamp) else $error("count not clamped");
  property p_bus;
    source == SRC_BUS && waiting_trigger && cmd_bus_trigger
      && delay_cfg == DLY_ZERO && quiet |-> ##3 sample_req;
  endproperty
  a_bus: assert property (p_bus) else $error("bus trigger late");
  property p_ign;
    source == SRC_BUS && waiting_trigger && !cmd_bus_trigger && quiet
      |=> waiting_trigger;
  endproperty
  a_ign: assert property (p_ign) else $error("foreign trigger taken");
  property p_wait;
    waiting_trigger |-> !sample_req;
  endproperty
  a_wait: assert property (p_wait) else $error("sample while waiting");
  property p_done;
    burst_done && source == SRC_BUS |-> waiting_trigger;
  endproperty
  a_done: assert property (p_done) else $error("not rearmed");
  property p_beep;
    beep |-> hold_capture && source == SRC_HOLD;
  endproperty
  a_beep: assert property (p_beep) else $error("stray beep");
  property p_pre;
    pretrig_active |-> waiting_trigger;
  endproperty
  a_pre: assert property (p_pre) else $error("pretrigger out of wait");
  c_burst: cover property (burst_done);
  c_hold: cover property (hold_capture);
  c_auto: cover property (sample_req && source == SRC_AUTO);
endmodule // trig_seq_chk
bind trigger_sequencer trig_seq_chk chk_u (
  .clock(clock), .rst_n(rst_n), .source_sel(source_sel),
  .source_load(source_load), .sample_count(sample_count),
  .count_load(count_load), .delay_load(delay_load),
  .cmd_configure(cmd_configure), .cmd_measure(cmd_measure),
  .cmd_abort(cmd_abort), .cmd_bus_trigger(cmd_bus_trigger),
  .remote_enter(remote_enter), .range_manual(range_manual),
  .sample_req(sample_req), .pretrig_active(pretrig_active),
  .waiting_trigger(waiting_trigger), .hold_capture(hold_capture),
  .beep(beep), .source(source), .count_cfg(count_cfg),
  .delay_cfg(delay_cfg), .burst_done(burst_done)
);
`default_nettype wire

// ---- verification/measurement_trigger_sequencer_tb.sv ----
// Purpose: Self-checking bench of the trigger sequencer
// Assumes: Zero delay mode for burst tests
// Notes:   Monitor pairs burst_done with queued sample counts
`default_nettype none
module measurement_trigger_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import trig_seq_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, slow = 1'b0, ext_pin = 1'b0;
  logic [13:0] cmd = 14'h0000;
  source_t src_sel = SRC_AUTO;
  logic [19:0] cnt_in = 20'h00001, pre_in = 20'h00000;
  logic [31:0] dly = 32'h00000000;
  logic sample_req, pretrig_active, waiting_trigger, hold_capture, beep;
  logic burst_done, done, hc, bp;
  logic beep_en = 1'b1;
  source_t source;
  delay_mode_t delay_cfg;
  logic [19:0] count_cfg;
  int num_errors = 0, check_count = 0, cycles = 0, seed = 89, n = 0, k;
  int q[$];
  always #12.5 clock = ~clock;
  trigger_sequencer dut_u (.clock(clock), .rst_n(rst_n),
    .source_sel(src_sel), .source_load(cmd[0]), .sample_count(cnt_in),
    .pretrigger_count(pre_in), .count_load(cmd[1]), .delay_mode(DLY_ZERO),
    .manual_delay_us(dly), .delay_load(cmd[2]), .meas_function(FN_DCV),
    .auto_delay_us(dly), .beeper_enable(beep_en), .cmd_configure(cmd[3]),
    .cmd_measure(cmd[4]), .cmd_arm(cmd[5]), .cmd_abort(cmd[6]),
    .cmd_bus_trigger(cmd[7]), .key_trigger(cmd[8]),
    .remote_enter(cmd[9]), .range_manual(cmd[10]),
    .ext_trig_pin(ext_pin), .ext_slope_pos(1'b1),
    .level_rising(cmd[11]), .level_falling(cmd[12]),
    .level_slope_pos(1'b1), .reading_stable(cmd[13]),
    .sample_done(done), .sample_req(sample_req),
    .pretrig_active(pretrig_active), .waiting_trigger(waiting_trigger),
    .hold_capture(hold_capture), .beep(beep), .source(source),
    .count_cfg(count_cfg), .pretrig_cfg(), .delay_cfg(delay_cfg),
    .burst_done(burst_done));
  engine_model eng_u (.clock(clock), .rst_n(rst_n),
    .sample_req(sample_req), .slow(slow), .sample_done(done));
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic pulse(input int b);
    @(posedge clock);
    #2 cmd[b] = 1'b1;
    @(posedge clock);
    #2 cmd[b] = 1'b0;
  endtask
  task automatic wait_burst();
    for (k = 0; k < 2000 && q.size() > 0; k++) @(posedge clock);
    check(20'(q.size()), 20'h00000);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (cmd[5]) n = 0;
    if (sample_req) n++;
    if (burst_done) begin
      check(20'(n), q.size() ? 20'(q.pop_front()) : 20'hfffff);
      n = 0;
    end
    if (++cycles > 20000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (12) @(posedge clock);
    #2 rst_n = 1'b1;
    pulse(6);
    pulse(3);
    check(20'(source), 20'(SRC_IMMEDIATE));
    pulse(4);
    check(20'(delay_cfg), 20'(DLY_AUTO));
    pulse(2);
    $display("test commands done");
    src_sel = SRC_BUS;
    pulse(0);
    for (int i = 0; i < 3; i++) begin
      slow = i[0];
      cnt_in = 20'($unsigned($random(seed)) % 4 + 1);
      pulse(1);
      pulse(5);
      pulse(8);
      pulse(11);
      check(20'(waiting_trigger), 20'h00001);
      q.push_back(int'(cnt_in));
      pulse(7);
      wait_burst();
    end
    cnt_in = 20'hfffff;
    pulse(1);
    check(count_cfg, 20'h0c350);
    $display("test bus done");
    src_sel = SRC_INTERNAL;
    pulse(0);
    cnt_in = 20'h00002;
    pre_in = 20'h00001;
    pulse(1);
    pulse(5);
    pulse(12);
    pulse(7);
    q.push_back(2);
    pulse(11);
    wait_burst();
    $display("test level done");
    src_sel = SRC_SINGLE;
    slow = 1'b1;
    pre_in = 20'h00000;
    pulse(0);
    pulse(5);
    q.push_back(2);
    q.push_back(2);
    for (int j = 0; j < 2; j++) begin
      #2 ext_pin = 1'b1;
      repeat (4) @(posedge clock);
      #2 ext_pin = 1'b0;
      repeat (10) @(posedge clock);
    end
    wait_burst();
    $display("test single done");
    src_sel = SRC_HOLD;
    pulse(0);
    hc = 1'b0;
    bp = 1'b0;
    @(posedge clock);
    #2 cmd[13] = 1'b1;
    repeat (8) begin
      @(posedge clock);
      #2 cmd[13] = 1'b0;
      hc = hc | hold_capture;
      bp = bp | beep;
    end
    check(20'(hc), 20'h00001);
    check(20'(bp), 20'(beep_en));
    pulse(10);
    check(20'(source), 20'(SRC_IMMEDIATE));
    $display("test hold done");
    src_sel = SRC_AUTO;
    slow = 1'b0;
    pulse(0);
    check(count_cfg, 20'h00000);
    k = 0;
    repeat (40) begin
      @(posedge clock);
      #1 k += int'(sample_req);
    end
    check(20'(k > 4), 20'h00001);
    pulse(6);
    $display("test auto done");
    stop_test();
  end
endmodule // measurement_trigger_sequencer_tb
`default_nettype wire
